// File: pkg/sgc_pkg.sv
// constants for the converter gain-scaling control block
// assumes a 32-bit apb register slave on a single 250 MHz clock
// Contract
// - gain setting comes from exactly thirteen programmable bits in three registers
// - upper eight gain word bits are the whole gain_word_high register
// - lower four gain word bits are gain_word_low bits 7 down to 4
// - extra_gain_bit in gain_extra_add bit 0 adds one sixty-fourth of gain
// - power-on reset leaves extra_gain_bit at one
// - effective gain equals word over 4096 plus extra bit times 1/64
// - reset values 0xfc high and 0x00 low give unity gain
// - effective gain stays between zero and about 1.015
`default_nettype none
package sgc_pkg;
  // register byte offsets
  localparam logic [11:0] SGC_OFS_HIGH = 12'h000;
  localparam logic [11:0] SGC_OFS_LOW = 12'h004;
  localparam logic [11:0] SGC_OFS_ADD = 12'h008;
  localparam logic [11:0] SGC_OFS_GAIN = 12'h00c;
  // reset values
  localparam logic [7:0] SGC_RST_HIGH = 8'hfc;
  localparam logic [7:0] SGC_RST_LOW = 8'h00;
  localparam logic SGC_RST_EXTRA = 1'b1;
  // field positions
  localparam int SGC_LOW_MSB = 7;
  localparam int SGC_LOW_LSB = 4;
  localparam int SGC_EXTRA_POS = 0;
  // gain word width and resolved gain scale: 1.0 = 4096
  localparam int SGC_WORD_W = 12;
  localparam int SGC_GAIN_W = 13;
  localparam logic [12:0] SGC_EXTRA_LSBS = 13'h0040;
endpackage : sgc_pkg
`default_nettype wire

// File: hw/sgc_gain_calc.sv
// combinational gain resolver: word plus optional 1/64 in units of 1/4096
// assumes inputs are register outputs of the control block
`default_nettype none
module sgc_gain_calc
  import sgc_pkg::*;
(
  // settings
  input wire logic [7:0] i_high,
  input wire logic [7:0] i_low,
  input wire logic i_extra,
  // result
  output logic [SGC_WORD_W-1:0] o_word,
  output logic [SGC_GAIN_W-1:0] o_gain
);
  // word assembly and sum, max 4095+64 fits 13 bits
  always_comb begin
    o_word = {i_high, i_low[SGC_LOW_MSB:SGC_LOW_LSB]};
    o_gain = {1'b0, o_word} + (i_extra ? SGC_EXTRA_LSBS : 13'h0000);
  end
endmodule : sgc_gain_calc
`default_nettype wire

// File: hw/sgc_top.sv
// apb-controlled gain-scaling registers for the converter datapath
// assumes synchronous apb master on I_SYS_CLK, async active-low reset
//
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
module sgc_top
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // resolved gain to converter datapath
  output logic [SGC_WORD_W-1:0] o_gain_word,
  output logic o_extra_gain_bit,
  output logic [SGC_GAIN_W-1:0] o_gain
);
  logic [7:0] high_reg;
  logic [7:0] low_reg;
  logic extra_reg;
  logic [SGC_WORD_W-1:0] word_next;
  logic [SGC_GAIN_W-1:0] gain_next;
  logic wr_acc;
  logic hit;

  // address decode, used for the error flag on both reads and writes
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == SGC_OFS_HIGH) || (a == SGC_OFS_LOW) || (a == SGC_OFS_ADD) || (a == SGC_OFS_GAIN);
  endfunction : is_mapped

  // reads and writes both complete in the first access cycle
  assign hit = is_mapped(i_paddr);
  assign wr_acc = i_psel && i_penable && i_pwrite;

  // gain registers, seventeen programmable bits in all, thirteen of them feed the gain
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      high_reg <= SGC_RST_HIGH;
      low_reg <= SGC_RST_LOW;
      extra_reg <= SGC_RST_EXTRA;
    end else if (wr_acc && i_pstrb[0]) begin
      if (i_paddr == SGC_OFS_HIGH) begin
        high_reg <= i_pwdata[7:0];
      end
      if (i_paddr == SGC_OFS_LOW) begin
        low_reg <= i_pwdata[7:0];
      end
      if (i_paddr == SGC_OFS_ADD) begin
        extra_reg <= i_pwdata[SGC_EXTRA_POS];
      end
    end
  end

  // gain resolution
  sgc_gain_calc u_calc (
    .i_high(high_reg),
    .i_low(low_reg),
    .i_extra(extra_reg),
    .o_word(word_next),
    .o_gain(gain_next)
  );

  // registered outputs to the datapath
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_gain_word <= {SGC_RST_HIGH, SGC_RST_LOW[SGC_LOW_MSB:SGC_LOW_LSB]};
      o_extra_gain_bit <= SGC_RST_EXTRA;
      o_gain <= 13'h1000;
    end else begin
      o_gain_word <= word_next;
      o_extra_gain_bit <= extra_reg;
      o_gain <= gain_next;
    end
  end

  // apb answer: ready pulse, read data and error for unmapped address
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        o_pready <= 1'b1;
        o_pslverr <= !hit;
        o_prdata <= 32'h0000_0000;
        if (!i_pwrite) begin
          unique case (i_paddr)
            SGC_OFS_HIGH: o_prdata <= {24'h000000, high_reg};
            SGC_OFS_LOW: o_prdata <= {24'h000000, low_reg};
            SGC_OFS_ADD: o_prdata <= {31'h00000000, extra_reg};
            SGC_OFS_GAIN: o_prdata <= {19'h00000, gain_next};
            default: o_prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // pready answers in the first access cycle
  a_ready_timing: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (i_psel && !i_penable) |=> o_pready)
    else $error("pready missing in access cycle");

  a_extra_reset: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    $rose(I_RST_N) |-> extra_reg)
    else $error("extra bit not one after reset");

  a_word_map: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ##1 o_gain_word[11:4] == $past(high_reg))
    else $error("gain word high mismatch");

  a_low_map: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ##1 o_gain_word[3:0] == $past(low_reg[7:4]))
    else $error("gain word low mismatch");

  a_extra_add: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ##1 o_gain == {1'b0, o_gain_word} + (o_extra_gain_bit ? 13'h0040 : 13'h0000))
    else $error("extra sixty-fourth not applied");

  a_gain_range: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    o_gain <= 13'h103f)
    else $error("gain out of range");

  a_low_ignored: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    ($stable(low_reg[7:4]) && $stable(high_reg) && $stable(extra_reg)) |-> $stable(gain_next))
    else $error("low nibble leaks into gain");

  a_write_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (wr_acc && i_pstrb[0] && i_paddr == SGC_OFS_HIGH) |=> ##1 o_gain_word[11:4] == $past(i_pwdata[7:0], 2))
    else $error("high write not seen at output");

  a_unity_default: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (high_reg == 8'hfc && low_reg[7:4] == 4'h0 && extra_reg) |-> gain_next == 13'h1000)
    else $error("default gain not unity");

  // error flag follows the address decode of the setup cycle
  a_slverr_map: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (i_psel && !i_penable) |=> (o_pslverr == !$past(hit)))
    else $error("pslverr does not match decode");

  // error only ever comes with ready
  a_slverr_ready: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    o_pslverr |-> o_pready)
    else $error("pslverr without pready");

  // ready is a single-cycle pulse
  a_ready_pulse: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");

  // high register read-back
  a_read_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (i_psel && !i_penable && !i_pwrite && i_paddr == SGC_OFS_HIGH) |=> o_prdata == {24'h000000, $past(high_reg)})
    else $error("high read-back wrong");

  // low register read-back, all eight bits
  a_read_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (i_psel && !i_penable && !i_pwrite && i_paddr == SGC_OFS_LOW) |=> o_prdata == {24'h000000, $past(low_reg)})
    else $error("low read-back wrong");

  // extra bit read-back, upper bits zero
  a_read_add: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (i_psel && !i_penable && !i_pwrite && i_paddr == SGC_OFS_ADD) |=> o_prdata == {31'h00000000, $past(extra_reg)})
    else $error("extra bit read-back wrong");

  // resolved gain read-back
  a_read_gain: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (i_psel && !i_penable && !i_pwrite && i_paddr == SGC_OFS_GAIN) |=> o_prdata == {19'h00000, $past(gain_next)})
    else $error("gain read-back wrong");

  // high write lands in the register
  a_store_high: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (wr_acc && i_pstrb[0] && i_paddr == SGC_OFS_HIGH) |=> high_reg == $past(i_pwdata[7:0]))
    else $error("high write lost");

  // low write lands in the register
  a_store_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (wr_acc && i_pstrb[0] && i_paddr == SGC_OFS_LOW) |=> low_reg == $past(i_pwdata[7:0]))
    else $error("low write lost");

  // extra bit write lands in the register
  a_store_extra: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (wr_acc && i_pstrb[0] && i_paddr == SGC_OFS_ADD) |=> extra_reg == $past(i_pwdata[SGC_EXTRA_POS]))
    else $error("extra bit write lost");

  // writes without byte strobe leave every setting alone
  a_strobe_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (wr_acc && !i_pstrb[0]) |=> ($stable(high_reg) && $stable(low_reg) && $stable(extra_reg)))
    else $error("strobe-less write changed a setting");

  // writes to unmapped places leave every setting alone
  a_unmapped_write: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    (wr_acc && !hit) |=> ($stable(high_reg) && $stable(low_reg) && $stable(extra_reg)))
    else $error("unmapped write changed a setting");

  // registered extra bit follows the register
  a_extra_out: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    o_extra_gain_bit == $past(extra_reg))
    else $error("extra bit output lags wrongly");

  // registered word follows the resolver
  a_word_out: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    o_gain_word == $past(word_next))
    else $error("gain word output lags wrongly");

  // registered gain follows the resolver
  a_gain_out: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    o_gain == $past(gain_next))
    else $error("gain output lags wrongly");
endmodule : sgc_top
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the gain-scaling registers
// assumes sgc_top answers apb with zero wait states
`default_nettype none
module tb_top
  import sgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, pen, pwr, e, ex, pready, pslverr, a;
  logic [3:0] strb;
  logic [7:0] h, l;
  logic [11:0] addr, gw;
  logic [12:0] g, gn;
  logic [31:0] wd, rd, prdata;
  int failures, samples_checked;
  // rows: high, low, add bit, expected gain in 1/4096
  logic [29:0] rows [7] = '{{8'hfc, 8'h00, 1'b1, 13'h1000}, {8'h7c, 8'h00, 1'b1, 13'h0800},
    {8'hbc, 8'h00, 1'b1, 13'h0c00}, {8'h3c, 8'h00, 1'b1, 13'h0400}, {8'hff, 8'hf0, 1'b0, 13'h0fff},
    {8'hff, 8'hf0, 1'b1, 13'h103f}, {8'h6c, 8'haf, 1'b1, 13'h070a}};
  sgc_top dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wd), .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_gain_word(gw), .o_extra_gain_bit(ex), .o_gain(gn));
  // clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // compare and count
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, s, x);
    end
  endtask : chk
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; addr <= ad; wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb
  task finish_test;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // watchdog against a hung handshake
  initial begin
    #20000;
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; addr = '0; wd = '0; strb = 4'hf;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'(gn), 32'h1000);
    chk(32'(gw), 32'hfc0);
    apb(1'b0, SGC_OFS_HIGH, '0); chk(rd, 32'hfc);
    chk(32'(e), 32'h0);
    apb(1'b0, SGC_OFS_LOW, '0); chk(rd, 32'h0);
    apb(1'b0, SGC_OFS_ADD, '0); chk(rd, 32'h1);
    foreach (rows[i]) begin
      {h, l, a, g} = rows[i];
      apb(1'b1, SGC_OFS_HIGH, 32'(h));
      apb(1'b1, SGC_OFS_LOW, 32'(l));
      apb(1'b1, SGC_OFS_ADD, 32'(a));
      repeat (2) @(posedge clk);
      chk(32'(gw), 32'({h, l[7:4]}));
      chk(32'(ex), 32'(a));
      chk(32'(gn), 32'(g));
      apb(1'b0, SGC_OFS_GAIN, '0); chk(rd, 32'(g));
      apb(1'b0, SGC_OFS_LOW, '0); chk(rd, 32'(l));
    end
    // strobe-less write must not land
    strb <= 4'h0;
    apb(1'b1, SGC_OFS_HIGH, 32'h11);
    strb <= 4'hf;
    apb(1'b0, SGC_OFS_HIGH, '0); chk(rd, 32'h6c);
    // unmapped place answers with error and zero
    apb(1'b1, 12'h010, 32'hff); chk(32'(e), 32'h1);
    apb(1'b0, 12'h010, '0); chk(32'(e), 32'h1);
    chk(rd, 32'h0);
    // second reset mid-run restores unity gain
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(gn), 32'h1000);
    chk(32'(ex), 32'h1);
    rst_n <= 1'b1;
    apb(1'b0, SGC_OFS_ADD, '0); chk(rd, 32'h1);
    apb(1'b0, SGC_OFS_HIGH, '0); chk(rd, 32'hfc);
    apb(1'b0, SGC_OFS_LOW, '0); chk(rd, 32'h0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
